/* File: common/rtccal_pkg.sv */
// rtccal_pkg: constants for the calendar counters and alarm block
package rtccal_pkg;

    // ------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SECOND_COUNT  = 8'h04;
    localparam logic [7:0] OFS_MINUTE_COUNT  = 8'h08;
    localparam logic [7:0] OFS_HOUR_COUNT    = 8'h0c;
    localparam logic [7:0] OFS_WEEKDAY_COUNT = 8'h10;
    localparam logic [7:0] OFS_DAY_COUNT     = 8'h14;
    localparam logic [7:0] OFS_MONTH_COUNT   = 8'h18;
    localparam logic [7:0] OFS_YEAR_COUNT    = 8'h1c;
    localparam logic [7:0] OFS_SECOND_ALARM  = 8'h20;
    localparam logic [7:0] OFS_MINUTE_ALARM  = 8'h24;
    localparam logic [7:0] OFS_CAL_STATUS    = 8'h38;
    localparam logic [7:0] OFS_CAL_CONTROL   = 8'h3c;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int unsigned ALM_ENABLE_BIT = 7;
    localparam int unsigned STAT_CARRY_BIT = 7;
    localparam int unsigned STAT_ALARM_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 0;
    localparam logic        START_RST      = 1'b1;
    localparam logic [7:0]  BCD_MAX_SEC    = 8'h59;
    localparam logic [7:0]  BCD_MAX_HOUR   = 8'h23;
    localparam logic [7:0]  BCD_MAX_MONTH  = 8'h12;
    localparam logic [7:0]  BCD_FIRST      = 8'h01;
    localparam logic [2:0]  WDAY_MAX       = 3'h6;
    localparam logic [7:0]  BCD_FEB        = 8'h02;
    localparam logic [7:0]  BCD_APR        = 8'h04;
    localparam logic [7:0]  BCD_JUN        = 8'h06;
    localparam logic [7:0]  BCD_SEP        = 8'h09;
    localparam logic [7:0]  BCD_NOV        = 8'h11;
    localparam logic [7:0]  DAYS_28        = 8'h28;
    localparam logic [7:0]  DAYS_29        = 8'h29;
    localparam logic [7:0]  DAYS_30        = 8'h30;
    localparam logic [7:0]  DAYS_31        = 8'h31;

endpackage

/* File: core/rtccal_calendar.sv */
// rtccal_calendar: second to year bcd counters, second/minute alarm
//
// Contract
// - hour counts bcd 00-23 on minute carry
// - weekday 0-6 Sunday-Saturday, daily on hour carry
// - day bcd 01-31, daily on hour carry
// - day range from month and leap year
// - month bcd 01-12 on day carry
// - year four-digit bcd 0000-9999 on month carry
// - calendar counters survive every reset
// - hour/day bits 7-6 read zero
// - weekday bits 7-3 read zero
// - month bits 7-5 read zero
// - alarm bit 7 enables its compare
// - alarm flag when all enabled alarms match
// - reset clears alarm enables, keeps values
// - second/minute alarms bcd 00-59, all bits rw
// - seconds advance on 1 Hz rising edge
// - minute counts on second carry, feeds hour
`timescale 1ns/1ns

module rtccal_calendar
(
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    input  wire logic                         ce_in,
    input  wire logic                         hz1_in,
    input  wire logic [rtccal_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [rtccal_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                         wr_in,
    input  wire logic                         rd_in,
    output logic      [rtccal_pkg::DATA_W-1:0] rd_data_out,
    output logic                              alarm_flag_out,
    output logic                              carry_flag_out
);
    import rtccal_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0]        sec;
        logic [6:0]        min;
        logic [5:0]        hour;
        logic [2:0]        wday;
        logic [5:0]        day;
        logic [4:0]        mon;
        logic [15:0]       year;
        logic [7:0]        sec_alm;
        logic [7:0]        min_alm;
        logic              start;
        logic              alarm_flag;
        logic              carry_flag;
        logic              hz_prev;
        logic [DATA_W-1:0] rd_data;
    } rtccal_state_s;

    rtccal_state_s s_r;
    rtccal_state_s s_nxt;

    // ------------------------------------------------------------
    // bcd helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9)
        begin
            r[3:0] = 4'h0;
            r[7:4] = v[7:4] + 4'h1;
        end
        else
        begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction

    // four digits, each rolls 9 to 0 and carries on
    function automatic logic [15:0] bcd_inc4(input logic [15:0] v);
        logic [15:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (c)
            begin
                if (v[i*4 +: 4] == 4'h9)
                begin
                    r[i*4 +: 4] = 4'h0;
                end
                else
                begin
                    r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // divisible by four, for a two-digit bcd value
    function automatic logic bcd_div4(input logic [7:0] v);
        logic u0;
        logic u2;
        u0 = (v[3:0] == 4'h0) || (v[3:0] == 4'h4) || (v[3:0] == 4'h8);
        u2 = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
        return v[4] ? u2 : u0;
    endfunction

    // last day of the month as bcd
    function automatic logic [7:0] month_len(input logic [7:0] m,
                                             input logic       leap);
        logic [7:0] r;
        r = DAYS_31;
        if (m == BCD_FEB)
        begin
            r = leap ? DAYS_29 : DAYS_28;
        end
        else if ((m == BCD_APR) || (m == BCD_JUN) ||
                 (m == BCD_SEP) || (m == BCD_NOV))
        begin
            r = DAYS_30;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // carry chain
    // ------------------------------------------------------------
    logic       tick;
    logic       leap;
    logic [7:0] last_day;
    logic       sec_cy;
    logic       min_cy;
    logic       hour_cy;
    logic       day_cy;
    logic       mon_cy;
    logic       sec_hit;
    logic       min_hit;
    logic       any_en;
    logic       alarm_match;

    always_comb
    begin
        tick = s_r.start && hz1_in && !s_r.hz_prev;
        // 400, 100 and 4 tests on the bcd year
        if (s_r.year[7:0] == 8'h00)
        begin
            leap = bcd_div4(s_r.year[15:8]);
        end
        else
        begin
            leap = bcd_div4(s_r.year[7:0]);
        end
        last_day = month_len({3'h0, s_r.mon}, leap);
        sec_cy   = tick && ({1'b0, s_r.sec} == BCD_MAX_SEC);
        min_cy   = sec_cy && ({1'b0, s_r.min} == BCD_MAX_SEC);
        hour_cy  = min_cy && ({2'h0, s_r.hour} == BCD_MAX_HOUR);
        day_cy   = hour_cy && ({2'h0, s_r.day} == last_day);
        mon_cy   = day_cy && ({3'h0, s_r.mon} == BCD_MAX_MONTH);
    end

    // ------------------------------------------------------------
    // alarm compare
    // ------------------------------------------------------------
    always_comb
    begin
        sec_hit = !s_r.sec_alm[ALM_ENABLE_BIT] ||
                  (s_r.sec_alm[6:0] == s_r.sec);
        min_hit = !s_r.min_alm[ALM_ENABLE_BIT] ||
                  (s_r.min_alm[6:0] == s_r.min);
        any_en  = s_r.sec_alm[ALM_ENABLE_BIT] ||
                  s_r.min_alm[ALM_ENABLE_BIT];
        alarm_match = any_en && sec_hit && min_hit;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.hz_prev = hz1_in;
        s_nxt.rd_data = '0;

        // counting
        if (tick)
        begin
            s_nxt.sec = sec_cy ? 7'h00 : 7'(bcd_inc({1'b0, s_r.sec}));
        end
        if (sec_cy)
        begin
            s_nxt.min = min_cy ? 7'h00 : 7'(bcd_inc({1'b0, s_r.min}));
        end
        if (min_cy)
        begin
            s_nxt.hour = hour_cy ? 6'h00 : 6'(bcd_inc({2'h0, s_r.hour}));
        end
        if (hour_cy)
        begin
            s_nxt.wday = (s_r.wday == WDAY_MAX) ? 3'h0 : s_r.wday + 3'h1;
            s_nxt.day  = day_cy ? BCD_FIRST[5:0] : 6'(bcd_inc({2'h0, s_r.day}));
        end
        if (day_cy)
        begin
            s_nxt.mon = mon_cy ? BCD_FIRST[4:0] : 5'(bcd_inc({3'h0, s_r.mon}));
        end
        if (mon_cy)
        begin
            s_nxt.year = bcd_inc4(s_r.year);
        end

        // flags: a hardware set wins over a clearing write
        if (wr_in && (addr_in == OFS_CAL_STATUS))
        begin
            if (!wr_data_in[STAT_CARRY_BIT])
            begin
                s_nxt.carry_flag = 1'b0;
            end
            if (!wr_data_in[STAT_ALARM_BIT])
            begin
                s_nxt.alarm_flag = 1'b0;
            end
        end
        if (sec_cy)
        begin
            s_nxt.carry_flag = 1'b1;
        end
        if (alarm_match)
        begin
            s_nxt.alarm_flag = 1'b1;
        end

        // register writes win over a count in the same cycle
        if (wr_in)
        begin
            unique case (addr_in)
                OFS_SECOND_COUNT:  s_nxt.sec     = wr_data_in[6:0];
                OFS_MINUTE_COUNT:  s_nxt.min     = wr_data_in[6:0];
                OFS_HOUR_COUNT:    s_nxt.hour    = wr_data_in[5:0];
                OFS_WEEKDAY_COUNT: s_nxt.wday    = wr_data_in[2:0];
                OFS_DAY_COUNT:     s_nxt.day     = wr_data_in[5:0];
                OFS_MONTH_COUNT:   s_nxt.mon     = wr_data_in[4:0];
                OFS_YEAR_COUNT:    s_nxt.year    = wr_data_in;
                OFS_SECOND_ALARM:  s_nxt.sec_alm = wr_data_in[7:0];
                OFS_MINUTE_ALARM:  s_nxt.min_alm = wr_data_in[7:0];
                OFS_CAL_CONTROL:   s_nxt.start   = wr_data_in[CTRL_START_BIT];
                default:           s_nxt.start   = s_r.start;
            endcase
        end

        // read data for the next cycle only
        if (rd_in)
        begin
            unique case (addr_in)
                OFS_SECOND_COUNT:  s_nxt.rd_data = {9'h000, s_r.sec};
                OFS_MINUTE_COUNT:  s_nxt.rd_data = {9'h000, s_r.min};
                OFS_HOUR_COUNT:    s_nxt.rd_data = {10'h000, s_r.hour};
                OFS_WEEKDAY_COUNT: s_nxt.rd_data = {13'h0000, s_r.wday};
                OFS_DAY_COUNT:     s_nxt.rd_data = {10'h000, s_r.day};
                OFS_MONTH_COUNT:   s_nxt.rd_data = {11'h000, s_r.mon};
                OFS_YEAR_COUNT:    s_nxt.rd_data = s_r.year;
                OFS_SECOND_ALARM:  s_nxt.rd_data = {8'h00, s_r.sec_alm};
                OFS_MINUTE_ALARM:  s_nxt.rd_data = {8'h00, s_r.min_alm};
                OFS_CAL_STATUS:    s_nxt.rd_data = {8'h00, s_r.carry_flag,
                                                    6'h00, s_r.alarm_flag};
                OFS_CAL_CONTROL:   s_nxt.rd_data = {15'h0000, s_r.start};
                default:           s_nxt.rd_data = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // counters and alarm values are left out of the reset on purpose
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_r.start                  <= START_RST;
            s_r.alarm_flag             <= 1'b0;
            s_r.carry_flag             <= 1'b0;
            s_r.hz_prev                <= 1'b0;
            s_r.rd_data                <= '0;
            s_r.sec_alm[ALM_ENABLE_BIT] <= 1'b0;
            s_r.min_alm[ALM_ENABLE_BIT] <= 1'b0;
        end
        else if (ce_in)
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb
    begin
        rd_data_out    = s_r.rd_data;
        alarm_flag_out = s_r.alarm_flag;
        carry_flag_out = s_r.carry_flag;
    end

endmodule

/* File: sim/rtccal_calendar_props.sv */
// rtccal_calendar_props: port-level checks for the calendar block
`timescale 1ns/1ns

module rtccal_calendar_props
(
    input wire logic                          clk_in,
    input wire logic                          rst_b_in,
    input wire logic                          ce_in,
    input wire logic                          hz1_in,
    input wire logic [rtccal_pkg::ADDR_W-1:0] addr_in,
    input wire logic [rtccal_pkg::DATA_W-1:0] wr_data_in,
    input wire logic                          wr_in,
    input wire logic                          rd_in,
    input wire logic [rtccal_pkg::DATA_W-1:0] rd_data_out,
    input wire logic                          alarm_flag_out,
    input wire logic                          carry_flag_out
);
    import rtccal_pkg::*;
    wire rd_ok = rd_in && ce_in;
    wire st_wr = wr_in && ce_in && addr_in == OFS_CAL_STATUS;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_hour_rng;
        rd_ok && addr_in == OFS_HOUR_COUNT |=> rd_data_out <= 16'h0023 && rd_data_out[3:0] <= 4'h9;
    endproperty
    a_hour_rng: assert property (p_hour_rng) else $error("hour read out of range");
    property p_day_rng;
        rd_ok && addr_in == OFS_DAY_COUNT |=> rd_data_out <= 16'h0031 && rd_data_out != 16'h0000;
    endproperty
    a_day_rng: assert property (p_day_rng) else $error("day read out of range");
    property p_wday_rng;
        rd_ok && addr_in == OFS_WEEKDAY_COUNT |=> rd_data_out <= 16'h0006;
    endproperty
    a_wday_rng: assert property (p_wday_rng) else $error("weekday read out of range");
    property p_mon_rng;
        rd_ok && addr_in == OFS_MONTH_COUNT |=> rd_data_out <= 16'h0012 && rd_data_out != 16'h0000;
    endproperty
    a_mon_rng: assert property (p_mon_rng) else $error("month read out of range");
    property p_year_bcd;
        rd_ok && addr_in == OFS_YEAR_COUNT |=> rd_data_out[15:12] <= 4'h9 && rd_data_out[11:8] <= 4'h9
            && rd_data_out[7:4] <= 4'h9 && rd_data_out[3:0] <= 4'h9;
    endproperty
    a_year_bcd: assert property (p_year_bcd) else $error("year digit not bcd");
    property p_carry_hold;
        carry_flag_out && ce_in && !(st_wr && !wr_data_in[7]) |=> carry_flag_out;
    endproperty
    a_carry_hold: assert property (p_carry_hold) else $error("carry flag dropped");
    property p_alarm_hold;
        alarm_flag_out && ce_in && !(st_wr && !wr_data_in[0]) |=> alarm_flag_out;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm flag dropped");
    property p_rst_alarm;
        $rose(rst_b_in) |-> !alarm_flag_out [*3];
    endproperty
    a_rst_alarm: assert property (p_rst_alarm) else $error("alarm flag after reset");
    property p_rd_idle;
        ce_in && !rd_in |=> rd_data_out == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_ce_hold;
        !ce_in |=> $stable(rd_data_out) && $stable(alarm_flag_out) && $stable(carry_flag_out);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved with clock enable low");

    c_alarm: cover property ($rose(alarm_flag_out));
    c_carry: cover property ($rose(carry_flag_out));
    c_year: cover property (rd_ok && addr_in == OFS_YEAR_COUNT);
endmodule

bind rtccal_calendar rtccal_calendar_props u_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .hz1_in(hz1_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .alarm_flag_out(alarm_flag_out), .carry_flag_out(carry_flag_out));

/* File: sim/rtccal_calendar_tb.sv */
// rtccal_calendar_tb: self-checking bench for the calendar block
`timescale 1ns/1ns

module rtccal_calendar_tb;
    import rtccal_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        ce_in = 1'b1;
    logic        hz1_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [15:0] wr_data_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [15:0] rd_data_out;
    logic        alarm_flag_out;
    logic        carry_flag_out;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [7:0]  offs [4] = '{OFS_HOUR_COUNT, OFS_WEEKDAY_COUNT, OFS_DAY_COUNT, OFS_MONTH_COUNT};
    // year, month, day, weekday, hour before and after one tick at 59:59
    logic [47:0] st_tab [9] = '{48'h2023_02_28_06_23, 48'h2024_02_28_01_23, 48'h2000_02_28_02_23,
        48'h2100_02_28_03_23, 48'h9999_12_31_04_23, 48'h2024_04_30_05_23, 48'h2019_11_19_00_09,
        48'h1999_09_30_01_23, 48'h2024_02_29_02_23};
    logic [47:0] ex_tab [9] = '{48'h2023_03_01_00_00, 48'h2024_02_29_02_00, 48'h2000_02_29_03_00,
        48'h2100_03_01_04_00, 48'h0000_01_01_05_00, 48'h2024_05_01_06_00, 48'h2019_11_19_00_10,
        48'h1999_10_01_02_00, 48'h2024_03_01_03_00};

    always #20 clk_in = ~clk_in;

    rtccal_calendar dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .hz1_in(hz1_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rd_data_out), .alarm_flag_out(alarm_flag_out), .carry_flag_out(carry_flag_out));

    task automatic close_out();
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(what, exp, rd_data_out);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    task automatic pulse();
        @(posedge clk_in);
        hz1_in <= 1'b1;
        @(posedge clk_in);
        hz1_in <= 1'b0;
    endtask

    task automatic roll_check(input logic [47:0] st, input logic [47:0] ex);
        wr(OFS_CAL_CONTROL, 16'h0000);
        wr(OFS_SECOND_COUNT, 16'h0059);
        wr(OFS_MINUTE_COUNT, 16'h0059);
        for (int i = 0; i < 4; i++)
            wr(offs[i], {8'h00, st[i*8+:8]});
        wr(OFS_YEAR_COUNT, st[47:32]);
        wr(OFS_CAL_STATUS, 16'h0000);
        wr(OFS_CAL_CONTROL, 16'h0001);
        pulse();
        settle();
        chk("carry flag", 16'h0001, {15'h0000, carry_flag_out});
        rd(OFS_CAL_STATUS, 16'h0080, "status");
        rd(OFS_SECOND_COUNT, 16'h0000, "second");
        rd(OFS_MINUTE_COUNT, 16'h0000, "minute");
        for (int i = 0; i < 4; i++)
            rd(offs[i], {8'h00, ex[i*8+:8]}, "calendar byte");
        rd(OFS_YEAR_COUNT, ex[47:32], "year");
    endtask

    task automatic hold_check();
        wr(OFS_CAL_CONTROL, 16'h0000);
        wr(OFS_SECOND_COUNT, 16'h0030);
        pulse();
        rd(OFS_SECOND_COUNT, 16'h0030, "second stopped");
        wr(OFS_CAL_CONTROL, 16'h0001);
        @(posedge clk_in);
        ce_in <= 1'b0;
        pulse();
        @(posedge clk_in);
        ce_in <= 1'b1;
        rd(OFS_SECOND_COUNT, 16'h0030, "second frozen");
        pulse();
        rd(OFS_SECOND_COUNT, 16'h0031, "second count");
    endtask

    task automatic alarm_check();
        wr(OFS_CAL_CONTROL, 16'h0000);
        wr(OFS_SECOND_COUNT, 16'h0010);
        wr(OFS_MINUTE_COUNT, 16'h0020);
        wr(OFS_SECOND_ALARM, 16'h0090);
        wr(OFS_MINUTE_ALARM, 16'h00a1);
        wr(OFS_CAL_STATUS, 16'h0000);
        settle();
        chk("alarm flag", 16'h0000, {15'h0000, alarm_flag_out});
        wr(OFS_MINUTE_ALARM, 16'h0021);
        wr(OFS_CAL_STATUS, 16'h0000);
        settle();
        chk("alarm flag", 16'h0001, {15'h0000, alarm_flag_out});
        wr(OFS_MINUTE_ALARM, 16'h00a0);
        wr(OFS_CAL_STATUS, 16'h0000);
        settle();
        chk("alarm flag", 16'h0001, {15'h0000, alarm_flag_out});
        wr(OFS_SECOND_ALARM, 16'h0091);
        wr(OFS_CAL_STATUS, 16'h0000);
        settle();
        chk("alarm flag", 16'h0000, {15'h0000, alarm_flag_out});
        rd(OFS_SECOND_ALARM, 16'h0091, "second alarm");
    endtask

    task automatic unused_bits();
        wr(OFS_HOUR_COUNT, 16'h00d9);
        rd(OFS_HOUR_COUNT, 16'h0019, "hour");
        wr(OFS_DAY_COUNT, 16'h00d8);
        rd(OFS_DAY_COUNT, 16'h0018, "day");
        wr(OFS_WEEKDAY_COUNT, 16'h00fd);
        rd(OFS_WEEKDAY_COUNT, 16'h0005, "weekday");
        wr(OFS_MONTH_COUNT, 16'h00f2);
        rd(OFS_MONTH_COUNT, 16'h0012, "month");
        wr(8'h40, 16'hffff);
        rd(8'h40, 16'h0000, "unmapped");
    endtask

    task automatic reset_keep();
        wr(OFS_HOUR_COUNT, 16'h0015);
        wr(OFS_MINUTE_ALARM, 16'h00a1);
        rst_b_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd(OFS_HOUR_COUNT, 16'h0015, "hour kept");
        rd(OFS_SECOND_ALARM, 16'h0011, "second alarm");
        rd(OFS_MINUTE_ALARM, 16'h0021, "minute alarm");
        chk("alarm flag", 16'h0000, {15'h0000, alarm_flag_out});
        rd(OFS_CAL_CONTROL, 16'h0001, "start after reset");
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            close_out();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 9; i++)
            roll_check(st_tab[i], ex_tab[i]);
        hold_check();
        alarm_check();
        unused_bits();
        reset_keep();
        close_out();
    end
endmodule
